// ==== design/uart_irq_core.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1 - Holding-empty interrupt while holding FIFO empty, masked by its own enable
// RQ2 - Transmission-complete interrupt after shift ends; next holding write clears it
// RQ3 - Data-ready while FIFO count reaches trigger, or buffer holds byte
// RQ4 - Time-out after four idle byte times below trigger; clears only when empty
// RQ5 - Data-ready and time-out share one enable, apart from line status enable
// RQ6 - Line status interrupt on parity, framing, overrun or break
// RQ7 - Nine-bit parity mismatch reported as address byte, raising line status
// RQ8 - In FIFO mode line status only for errored head byte; status read drops it
// RQ9 - Summary error flag set while any errored byte stays in receive FIFO
// RQ10 - Modem status interrupt on any modem input change; status read clears it
// RQ11 - Reset restores control and status defaults and flushes both FIFOs; reset here flushes only the transmit FIFO, the receive FIFO is outside
// RQ12 - Address-mark select auto-clears once its byte is fully sent
// RQ13 - Host waits for transmitter idle, then sets address mark with parity
// RQ14 - Host treats line status cause as address mark, ignoring parity error
// RQ15 - Receiver always active; no receiver enable exists
// RQ16 - Host polls status registers when interrupts are disabled
// RQ17 - Sixteen-bit downcounter to 0001h, then reloads with one-cycle pulse
// RQ18 - Divisor resets to 0002h
// RQ19 - Divisor byte write loads counter at once and restarts
// RQ20 - Divisor bytes reachable only while line control bit 7 set
// RQ21 - Host sets bit 7, writes divisor bytes, clears bit 7
// RQ22 - Host writes up to sixteen bytes per transmit interrupt; the transmit FIFO here is FIFO_DEPTH (8) deep
// RQ23 - One serial bit each sixteen end-of-count pulses
// RQ24 - Least significant bit first; output idles high
// RQ25 - Interrupt output is OR of enabled pending sources
module uart_irq_core #(
    parameter int FIFO_W = 8,
    parameter int FIFO_D = uart_irq_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Register access strobes
    input wire logic thr_wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic lctl_wr_in,
    input wire logic div_lo_wr_in,
    input wire logic div_hi_wr_in,
    input wire logic rbr_rd_in,
    input wire logic lsr_rd_in,
    input wire logic msr_rd_in,
    input wire logic [4:0] int_enable_in,
    input wire logic fifo_en_in,
    input wire logic nine_bit_in,
    // Receive side status
    input wire logic [4:0] rx_count_in,
    input wire logic [4:0] rx_trigger_in,
    input wire logic rx_fifo_wr_in,
    input wire logic rx_head_err_in,
    input wire logic rx_any_err_in,
    input wire logic parity_err_in,
    input wire logic framing_err_in,
    input wire logic overrun_in,
    input wire logic break_in,
    // Pins
    input wire logic [3:0] modem_pins_in,
    input wire logic rx_pin_in,
    output logic tx_pin_out,
    // Status out
    output logic irq_out,
    output logic [2:0] cause_out,
    output logic [7:0] lctl_out,
    output logic [15:0] divisor_out,
    output logic baud_tick_out,
    output logic holding_empty_out,
    output logic tx_idle_out,
    output logic err_summary_out,
    output logic rx_sample_out,
    output logic thr_ready_out
);
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} tx_st_t;
    typedef struct packed {
        logic [15:0] div;
        logic [15:0] cnt;
        logic tick;
        logic [7:0] lctl;
        tx_st_t txs;
        logic [3:0] sub;
        logic [3:0] bitn;
        logic [10:0] shreg;
        logic mark_sent;
        logic tcomp;
        logic line_p;
        logic msr_p;
        logic to_p;
        logic [7:0] idle_ticks;
        logic [2:0] idle_bytes;
        logic [3:0] m_s1, m_s2, m_s3;
        logic rx_s1, rx_s2;
        logic tx;
        logic irq;
        logic [2:0] cause;
        logic herr, aerr, idle, head_ack;
    } st_t;
    st_t q, d;
    logic f_valid, f_pop;
    logic [7:0] f_data;
    logic rx_rdy, line_src, dlab, tx_done;
    assign dlab = q.lctl[uart_irq_pkg::LCTL_DLAB_BIT];
    assign tx_done = q.txs == TX_SHIFT && q.tick && q.sub == uart_irq_pkg::BIT_TICKS_LAST
        && q.bitn == uart_irq_pkg::FRAME_BITS_LAST;
    assign f_pop = q.txs == TX_IDLE && q.tick;
    tx_data_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .flush_in(1'b0),
        .wr_valid_in(thr_wr_in && !dlab),
        .wr_ready_out(thr_ready_out),
        .wr_data_in(wdata_in),
        .rd_valid_out(f_valid),
        .rd_ready_in(f_pop),
        .rd_data_out(f_data)
    );
    // Data-ready level: trigger in FIFO mode, any byte otherwise
    assign rx_rdy = fifo_en_in ? (rx_count_in >= rx_trigger_in) : (rx_count_in != 5'h00); // RQ3
    always_comb begin
        d = q;
        d.rx_s1 = rx_pin_in;
        d.rx_s2 = q.rx_s1; // RQ15
        d.m_s1 = modem_pins_in;
        d.m_s2 = q.m_s1;
        d.m_s3 = q.m_s2;
        d.tick = 1'b0;
        // Baud divisor counter
        if (q.cnt == uart_irq_pkg::COUNT_END) begin
            d.cnt = q.div; // RQ17
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt - 16'h0001;
        end
        if (div_lo_wr_in && dlab) begin // RQ20
            d.div = {q.div[15:8], wdata_in};
            d.cnt = {q.div[15:8], wdata_in}; // RQ19
        end
        if (div_hi_wr_in && dlab) begin // RQ20
            d.div = {wdata_in, q.div[7:0]};
            d.cnt = {wdata_in, q.div[7:0]}; // RQ19
        end
        if (lctl_wr_in) begin
            d.lctl = wdata_in;
        end
        // Transmitter: 16 ticks per bit, LSB first, idle high
        case (q.txs)
            TX_IDLE: begin
                d.tx = 1'b1; // RQ24
                if (f_pop && f_valid) begin
                    d.shreg = {1'b1, q.lctl[uart_irq_pkg::LCTL_ADDR_MARK_BIT], f_data, 1'b0};
                    d.mark_sent = q.lctl[uart_irq_pkg::LCTL_ADDR_MARK_BIT];
                    d.txs = TX_SHIFT;
                    d.sub = 4'h0;
                    d.bitn = 4'h0;
                end
            end
            TX_SHIFT: begin
                d.tx = q.shreg[0]; // RQ24
                if (q.tick) begin
                    d.sub = q.sub + 4'h1;
                    if (q.sub == uart_irq_pkg::BIT_TICKS_LAST) begin // RQ23
                        d.shreg = {1'b1, q.shreg[10:1]};
                        d.bitn = q.bitn + 4'h1;
                        if (tx_done) begin
                            d.txs = TX_IDLE;
                            d.tcomp = 1'b1; // RQ2
                            if (q.mark_sent) begin
                                d.lctl[uart_irq_pkg::LCTL_ADDR_MARK_BIT] = 1'b0; // RQ12
                            end
                        end
                    end
                end
            end
            default: d.txs = TX_IDLE;
        endcase
        if (thr_wr_in && !dlab && !tx_done) begin
            d.tcomp = 1'b0; // RQ2
        end
        // Time-out: idle byte times counted in 16x ticks
        if (rbr_rd_in || rx_fifo_wr_in || rx_count_in == 5'h00 || rx_rdy) begin
            d.idle_ticks = 8'h00;
            d.idle_bytes = 3'h0;
        end else if (q.tick && q.idle_bytes != 3'(uart_irq_pkg::TIMEOUT_BYTES)) begin
            if (q.idle_ticks == 8'(uart_irq_pkg::OVERSAMPLE * uart_irq_pkg::BITS_PER_BYTE - 1)) begin
                d.idle_ticks = 8'h00;
                d.idle_bytes = q.idle_bytes + 3'h1;
            end else begin
                d.idle_ticks = q.idle_ticks + 8'h01;
            end
        end
        if (rx_count_in == 5'h00) begin
            d.to_p = 1'b0; // RQ4
        end else if (q.idle_bytes == 3'(uart_irq_pkg::TIMEOUT_BYTES)) begin
            d.to_p = 1'b1; // RQ4
        end
        // Line status: set wins over read clear outside FIFO mode
        line_src = parity_err_in || framing_err_in || overrun_in || break_in; // RQ6 RQ7
        if (fifo_en_in) begin
            // A read quiets the head byte until it leaves or turns clean
            if (lsr_rd_in) begin
                d.head_ack = 1'b1;
            end else if (rbr_rd_in || !rx_head_err_in) begin
                d.head_ack = 1'b0;
            end
            d.line_p = rx_head_err_in && !q.head_ack && !lsr_rd_in; // RQ8
        end else begin
            if (lsr_rd_in) begin
                d.line_p = 1'b0;
            end
            if (line_src) begin
                d.line_p = 1'b1; // RQ6
            end
        end
        if (msr_rd_in) begin
            d.msr_p = 1'b0;
        end
        if (q.m_s3 != q.m_s2) begin
            d.msr_p = 1'b1; // RQ10
        end
        d.herr = !f_valid; // RQ1
        d.idle = !f_valid && q.txs == TX_IDLE; // RQ13
        d.aerr = rx_any_err_in; // RQ9
        // Priority encode and combine enabled sources
        d.cause = uart_irq_pkg::CAUSE_NONE;
        d.irq = 1'b1;
        if (q.line_p && int_enable_in[uart_irq_pkg::ENA_LSR_BIT]) begin
            d.cause = uart_irq_pkg::CAUSE_LINE;
        end else if (rx_rdy && int_enable_in[uart_irq_pkg::ENA_RX_BIT]) begin // RQ5
            d.cause = uart_irq_pkg::CAUSE_RX;
        end else if (q.to_p && int_enable_in[uart_irq_pkg::ENA_RX_BIT]) begin // RQ5
            d.cause = uart_irq_pkg::CAUSE_TIMEOUT;
        end else if (!f_valid && int_enable_in[uart_irq_pkg::ENA_HOLD_BIT]) begin // RQ1
            d.cause = uart_irq_pkg::CAUSE_HOLD;
        end else if (q.tcomp && int_enable_in[uart_irq_pkg::ENA_TCIE_BIT]) begin // RQ2
            d.cause = uart_irq_pkg::CAUSE_TCOMP;
        end else if (q.msr_p && int_enable_in[uart_irq_pkg::ENA_MSR_BIT]) begin
            d.cause = uart_irq_pkg::CAUSE_MODEM;
        end else begin
            d.irq = 1'b0; // RQ25
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin // RQ11
            q <= '0;
            q.div <= uart_irq_pkg::DIVISOR_RESET; // RQ18
            q.cnt <= uart_irq_pkg::DIVISOR_RESET;
            q.lctl <= uart_irq_pkg::LCTL_RESET;
            q.txs <= TX_IDLE;
            q.tx <= 1'b1;
            q.rx_s1 <= 1'b1;
            q.rx_s2 <= 1'b1;
            q.herr <= 1'b1;
            q.idle <= 1'b1;
            q.cause <= uart_irq_pkg::CAUSE_NONE;
        end else begin
            q <= d;
        end
    end
    assign irq_out = q.irq;
    assign cause_out = q.cause;
    assign lctl_out = q.lctl;
    assign divisor_out = q.div;
    assign baud_tick_out = q.tick;
    assign holding_empty_out = q.herr;
    assign tx_idle_out = q.idle;
    assign err_summary_out = q.aerr;
    assign rx_sample_out = q.rx_s2;
    assign tx_pin_out = q.tx;
    // Checks
    sequence count_end_s;
        q.cnt == uart_irq_pkg::COUNT_END && !(dlab && (div_lo_wr_in || div_hi_wr_in));
    endsequence
    reload_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ17
        count_end_s |=> q.tick && q.cnt == $past(q.div)) else $error("no reload at count end");
    tick_single_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ17
        q.tick |=> !q.tick || q.div == 16'h0001) else $error("tick longer than one cycle");
    divisor_reset_a: assert property (@(posedge clk_in) // RQ18
        !rst_b_in |=> q.div == uart_irq_pkg::DIVISOR_RESET) else $error("divisor reset wrong");
    div_load_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ19
        dlab && div_lo_wr_in |=> q.cnt == {$past(q.div[15:8]), $past(wdata_in)}) else $error("low load missed");
    div_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ20
        !dlab && !lctl_wr_in ##1 1'b1 |-> $stable(q.div)) else $error("divisor changed with access off");
    mark_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ12
        tx_done && q.mark_sent && !lctl_wr_in |=> !q.lctl[uart_irq_pkg::LCTL_ADDR_MARK_BIT])
        else $error("address mark not cleared");
    tcomp_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ2
        tx_done |=> q.tcomp) else $error("completion flag not set");
    line_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ8
        fifo_en_in && lsr_rd_in |=> !q.line_p) else $error("line status not dropped");
    modem_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ10
        q.m_s3 != q.m_s2 |=> q.msr_p) else $error("modem change missed");
    idle_high_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ24
        q.txs == TX_IDLE && $past(q.txs) == TX_IDLE |-> tx_pin_out) else $error("idle line not high");
    irq_or_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RQ25
        q.msr_p && int_enable_in[uart_irq_pkg::ENA_MSR_BIT] && $stable(int_enable_in) |=> irq_out)
        else $error("enabled source without interrupt");
endmodule
`default_nettype wire

// ==== design/uart_irq_pkg.sv ====
package uart_irq_pkg;
    localparam logic [15:0] DIVISOR_RESET = 16'h0002;
    localparam logic [15:0] COUNT_END = 16'h0001;
    localparam int LCTL_DLAB_BIT = 7;
    localparam int LCTL_ADDR_MARK_BIT = 4;
    localparam int LCTL_PARITY_ON_BIT = 3;
    localparam logic [7:0] LCTL_RESET = 8'h00;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam int ENA_RX_BIT = 0;
    localparam int ENA_HOLD_BIT = 1;
    localparam int ENA_LSR_BIT = 2;
    localparam int ENA_MSR_BIT = 3;
    localparam int ENA_TCIE_BIT = 4;
    localparam int OVERSAMPLE = 16;
    localparam int TIMEOUT_BYTES = 4;
    localparam int BITS_PER_BYTE = 10;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] BIT_TICKS_LAST = 4'hF;
    localparam logic [3:0] FRAME_BITS_LAST = 4'hA;
    localparam logic [2:0] CAUSE_LINE = 3'h3;
    localparam logic [2:0] CAUSE_RX = 3'h2;
    localparam logic [2:0] CAUSE_TIMEOUT = 3'h6;
    localparam logic [2:0] CAUSE_HOLD = 3'h1;
    localparam logic [2:0] CAUSE_TCOMP = 3'h5;
    localparam logic [2:0] CAUSE_MODEM = 3'h0;
    localparam logic [2:0] CAUSE_NONE = 3'h7;
endpackage

// ==== design/tx_data_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module tx_data_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic flush_in,
    // Fill side
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Drain side
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic [WIDTH-1:0] dout;
        logic rdy;
    } fifo_state_t;
    logic [WIDTH-1:0] mem_q [DEPTH];
    fifo_state_t s_q, s_d;
    logic full, empty, push, pop;
    assign empty = s_q.wp == s_q.rp;
    assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
    assign push = wr_valid_in && !full;
    assign pop = rd_ready_in && !empty;
    assign wr_ready_out = s_q.rdy;
    assign rd_valid_out = !empty;
    assign rd_data_out = s_q.dout;
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        if (flush_in) begin
            s_d.wp = '0;
            s_d.rp = '0;
        end
        // Head word registered; bypass when it is being written now
        s_d.dout = mem_q[s_d.rp[AW-1:0]];
        if (push && s_d.rp == s_q.wp) begin
            s_d.dout = wr_data_in;
        end
        s_d.rdy = !((s_d.wp[AW] != s_d.rp[AW]) && (s_d.wp[AW-1:0] == s_d.rp[AW-1:0]));
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[s_q.wp[AW-1:0]] <= wr_data_in;
        end
    end
    count_bound_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (s_q.wp - s_q.rp) <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ==== tb/remote_station.sv ====
`timescale 1ns/10ps
`default_nettype none
module remote_station #(
    parameter int BIT_CYC = 32
) (
    // Clock
    input wire logic clk_in,
    // Serial lines
    input wire logic line_in,
    output logic line_out,
    // Last frame seen, stop bit on top
    output logic [9:0] got_out,
    output var int frames_out
);
    // Remote stays silent; its line rests at the mark level
    assign line_out = 1'b1;
    // Samples mid-bit so a tick of jitter cannot flip a bit
    initial begin
        got_out = 10'h000;
        frames_out = 0;
        forever begin
            @(negedge line_in);
            repeat (BIT_CYC / 2) @(posedge clk_in);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT_CYC) @(posedge clk_in);
                got_out[i] = line_in;
            end
            frames_out = frames_out + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/uart_irq_core_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module uart_irq_core_bench;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [6:0] stb = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [4:0] ena = 5'h00;
    logic [4:0] cnt = 5'h00;
    logic [4:0] trig = 5'h04;
    logic fifo_en = 1'b0;
    logic nine = 1'b0;
    logic rx_wr = 1'b0;
    logic head_err = 1'b0;
    logic any_err = 1'b0;
    logic [3:0] errs = 4'h0;
    logic [3:0] modem = 4'h0;
    logic rx_line, tx_line, irq, tick, h_empty, tx_idle, err_sum, thr_rdy, rx_smp;
    logic [2:0] cause;
    logic [7:0] lctl;
    logic [15:0] divisor;
    logic [9:0] got;
    int frames, f0, n;
    int n_fail = 0;
    int checks_done = 0;

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    uart_irq_core dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .thr_wr_in(stb[0]), .wdata_in(wdata),
        .lctl_wr_in(stb[1]), .div_lo_wr_in(stb[2]), .div_hi_wr_in(stb[3]), .rbr_rd_in(stb[4]),
        .lsr_rd_in(stb[5]), .msr_rd_in(stb[6]), .int_enable_in(ena), .fifo_en_in(fifo_en),
        .nine_bit_in(nine), .rx_count_in(cnt), .rx_trigger_in(trig), .rx_fifo_wr_in(rx_wr),
        .rx_head_err_in(head_err), .rx_any_err_in(any_err), .parity_err_in(errs[0]),
        .framing_err_in(errs[1]), .overrun_in(errs[2]), .break_in(errs[3]), .modem_pins_in(modem),
        .rx_pin_in(rx_line), .tx_pin_out(tx_line), .irq_out(irq), .cause_out(cause), .lctl_out(lctl),
        .divisor_out(divisor), .baud_tick_out(tick), .holding_empty_out(h_empty),
        .tx_idle_out(tx_idle), .err_summary_out(err_sum), .rx_sample_out(rx_smp), .thr_ready_out(thr_rdy));

    // Divisor 2 gives 16 ticks of 2 cycles per bit
    remote_station #(.BIT_CYC(32)) far (.clk_in(clk_in), .line_in(tx_line), .line_out(rx_line),
        .got_out(got), .frames_out(frames));

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge clk_in);
    endtask

    // Strobes: 0 holding, 1 line control, 2/3 divisor bytes, 4/5/6 reads
    task automatic put(input int idx, input logic [7:0] d);
        step(1);
        wdata = d;
        stb[idx] = 1'b1;
        step(1);
        stb = 7'h00;
    endtask

    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && irq !== 1'b1; i++) step(1);
        if (irq !== 1'b1) begin
            n_fail++;
            $display("MISMATCH irq wait expected 1 seen %b", irq);
        end
    endtask

    task automatic wait_idle;
        step(8);
        for (int i = 0; i < 8000 && tx_idle !== 1'b1; i++) step(1);
        if (tx_idle !== 1'b1) begin
            n_fail++;
            $display("MISMATCH idle wait expected 1 seen %b", tx_idle);
        end
    endtask

    task automatic gap(input logic [15:0] exp);
        int g;
        for (g = 0; g < 64 && tick !== 1'b1; g++) step(1);
        step(1);
        for (g = 1; g < 64 && tick !== 1'b1; g++) step(1);
        chk("tick gap", exp, g[15:0]);
    endtask

    initial begin
        repeat (40000) @(posedge clk_in);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        step(16);
        rst_b_in = 1'b1;
        step(1);
        chk("divisor", 16'h0002, divisor);
        chk("lctl", 16'h0000, {8'h00, lctl});
        chk("tx pin", 16'h0001, {15'h0, tx_line});
        chk("irq", 16'h0000, {15'h0, irq});
        chk("holding empty", 16'h0001, {15'h0, h_empty});
        chk("rx sample", 16'h0001, {15'h0, rx_smp});
        gap(16'h0002);
        put(2, 8'h07);
        chk("divisor locked", 16'h0002, divisor);
        put(1, 8'h80);
        put(2, 8'h05);
        chk("divisor low", 16'h0005, divisor);
        gap(16'h0005);
        put(2, 8'h02);
        put(1, 8'h00);
        gap(16'h0002);
        ena = 5'h02;
        wait_irq(10);
        chk("holding_empty_flag cause", 16'h0001, {13'h0, cause});
        chk("irq", 16'h0001, {15'h0, irq});
        ena = 5'h00;
        step(3);
        chk("irq masked", 16'h0000, {15'h0, irq});
        put(0, 8'hA5);
        wait_idle();
        chk("frame", 16'h02A5, {6'h0, got});
        ena = 5'h10;
        wait_irq(10);
        chk("tcomp cause", 16'h0005, {13'h0, cause});
        put(0, 8'h3C);
        step(2);
        chk("tcomp cleared", 16'h0000, {15'h0, irq});
        ena = 5'h00;
        wait_idle();
        put(1, 8'h18);
        nine = 1'b1;
        put(0, 8'h81);
        wait_idle();
        chk("mark auto clear", 16'h0008, {8'h00, lctl});
        chk("address frame", 16'h0381, {6'h0, got});
        put(0, 8'h42);
        wait_idle();
        chk("data frame", 16'h0242, {6'h0, got});
        put(1, 8'h00);
        f0 = frames;
        n = 0;
        for (int i = 0; i < 12; i++) begin
            if (thr_rdy === 1'b1) begin
                put(0, 8'h50 + i[7:0]);
                n++;
            end
        end
        chk("fifo full", 16'h0000, {15'h0, thr_rdy});
        chk("accepted", 16'(uart_irq_pkg::FIFO_DEPTH + 1), n[15:0]);
        chk("holding empty", 16'h0000, {15'h0, h_empty});
        chk("tx busy", 16'h0000, {15'h0, tx_idle});
        wait_idle();
        chk("frames sent", n[15:0], 16'(frames - f0));
        chk("last frame", {6'h0, 2'h2, 8'h4F + n[7:0]}, {6'h0, got});
        ena = 5'h01;
        fifo_en = 1'b1;
        cnt = 5'h04;
        wait_irq(10);
        chk("rx cause", 16'h0002, {13'h0, cause});
        cnt = 5'h03;
        step(3);
        chk("below trigger", 16'h0000, {15'h0, irq});
        fifo_en = 1'b0;
        cnt = 5'h01;
        wait_irq(10);
        chk("buffer full", 16'h0002, {13'h0, cause});
        cnt = 5'h00;
        put(4, 8'h00);
        step(2);
        chk("buffer read", 16'h0000, {15'h0, irq});
        fifo_en = 1'b1;
        cnt = 5'h02;
        rx_wr = 1'b1;
        step(1);
        rx_wr = 1'b0;
        step(1000);
        chk("no early timeout", 16'h0000, {15'h0, irq});
        wait_irq(600);
        chk("timeout cause", 16'h0006, {13'h0, cause});
        ena = 5'h04;
        step(3);
        chk("shared mask", 16'h0000, {15'h0, irq});
        ena = 5'h01;
        put(4, 8'h00);
        step(2);
        chk("timeout holds", 16'h0001, {15'h0, irq});
        cnt = 5'h00;
        step(3);
        chk("timeout cleared", 16'h0000, {15'h0, irq});
        fifo_en = 1'b0;
        ena = 5'h04;
        for (int k = 0; k < 4; k++) begin
            errs = 4'h1 << k;
            step(1);
            errs = 4'h0;
            wait_irq(6);
            chk("line cause", 16'h0003, {13'h0, cause});
            put(5, 8'h00);
            step(2);
            chk("line cleared", 16'h0000, {15'h0, irq});
        end
        fifo_en = 1'b1;
        head_err = 1'b1;
        any_err = 1'b1;
        wait_irq(6);
        chk("head error", 16'h0003, {13'h0, cause});
        chk("err summary", 16'h0001, {15'h0, err_sum});
        put(5, 8'h00);
        step(1);
        chk("read drops", 16'h0000, {15'h0, irq});
        head_err = 1'b0;
        any_err = 1'b0;
        step(2);
        chk("err summary", 16'h0000, {15'h0, err_sum});
        ena = 5'h08;
        modem = 4'h1;
        wait_irq(10);
        chk("modem cause", 16'h0000, {13'h0, cause});
        put(6, 8'h00);
        step(2);
        chk("modem cleared", 16'h0000, {15'h0, irq});
        ena = 5'h00;
        put(1, 8'h80);
        put(2, 8'h09);
        chk("divisor nine", 16'h0009, divisor);
        put(1, 8'h00);
        put(0, 8'h11);
        put(0, 8'h22);
        rst_b_in = 1'b0;
        step(2);
        rst_b_in = 1'b1;
        step(1);
        chk("divisor", 16'h0002, divisor);
        chk("flushed", 16'h0001, {15'h0, h_empty});
        chk("tx pin", 16'h0001, {15'h0, tx_line});
        tally_and_finish();
    end
endmodule
`default_nettype wire
